// *** logic/msp_pkg.sv ***
// constants and carrier types of the serial host port
`default_nettype none

package msp_pkg;

  localparam int unsigned BYTE_BITS   = 8;
  localparam int unsigned XFER_BYTES  = 128;
  localparam int unsigned CLASS_BYTES = XFER_BYTES / 2;
  localparam int unsigned TX_DEPTH    = 16;
  localparam int unsigned RC_FLAG_BIT = 7;
  localparam int unsigned PIN_SS      = 2;
  localparam int unsigned PIN_SCLK    = 1;
  localparam int unsigned PIN_MOSI    = 0;
  localparam int unsigned PIN_W       = 3;
  localparam logic [2:0]  BIT_FIRST   = 3'h0;
  localparam logic [2:0]  BIT_LAST    = 3'h7;
  localparam logic [7:0]  IDLE_FILL   = 8'h00;
  localparam logic [2:0]  PIN_RST     = 3'h4;

  // one received byte and whether it opened its frame
  typedef struct packed {
    logic                 first;
    logic [BYTE_BITS-1:0] data;
  } msp_rx_t;

  typedef enum logic {
    ST_IDLE,
    ST_ACTIVE
  } msp_state_t;

endpackage

`default_nettype wire

// *** logic/msp_sync.sv ***
// two flip-flop synchroniser for pin levels
`default_nettype none

module msp_sync #(
  parameter int unsigned  W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_sys, // system clock
  input  wire logic         rst_n,   // synchronous reset, low
  input  wire logic [W-1:0] d,       // asynchronous levels
  output logic      [W-1:0] sync_q   // synchronised levels
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;

  always_comb
  begin
    meta_d = d;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

endmodule

`default_nettype wire

// *** logic/msp_fifo.sv ***
// flip-flop FIFO with registered head and valid/ready on both sides
`default_nettype none

module msp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_sys,   // system clock
  input  wire logic             rst_n,     // synchronous reset, low
  input  wire logic             in_valid,  // word offered
  input  wire logic [WIDTH-1:0] in_data,   // word in
  output logic                  in_ready,  // room for a word
  output logic                  out_valid, // head word present
  output logic      [WIDTH-1:0] out_data,  // head word
  input  wire logic             out_ready  // head word taken
);

  localparam int unsigned   PW       = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned   CW       = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0]    cnt_q, cnt_d;
  logic             in_ready_d, out_valid_d;
  logic [WIDTH-1:0] out_data_d;
  logic             push, load;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == PTR_LAST) ? '0 : p + 1'b1;
  endfunction

  always_comb
  begin
    mem_d       = mem_q;
    push        = in_valid && in_ready;
    load        = (!out_valid || out_ready) && (cnt_q != '0);
    wr_d        = wr_q;
    rd_d        = rd_q;
    out_valid_d = out_valid && !out_ready;
    out_data_d  = out_data;
    if (push)
    begin
      mem_d[wr_q] = in_data;
      wr_d        = ptr_inc(wr_q);
    end
    if (load)
    begin
      out_data_d  = mem_q[rd_q];
      out_valid_d = 1'b1;
      rd_d        = ptr_inc(rd_q);
    end
    cnt_d      = cnt_q + CW'(push) - CW'(load);
    in_ready_d = (cnt_d != CNT_FULL);
  end

  always_ff @(posedge clk_sys)
  begin
    mem_q <= mem_d;
    if (!rst_n)
    begin
      wr_q      <= '0;
      rd_q      <= '0;
      cnt_q     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else
    begin
      wr_q      <= wr_d;
      rd_q      <= rd_d;
      cnt_q     <= cnt_d;
      in_ready  <= in_ready_d;
      out_valid <= out_valid_d;
      out_data  <= out_data_d;
    end
  end

  fifo_full_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (cnt_q == CNT_FULL) |-> !in_ready)
    else $error("fifo offers room while full");

  head_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (out_valid && !out_ready) |=> (out_valid && $stable(out_data)))
    else $error("fifo head changed while stalled");

endmodule

`default_nettype wire

// *** logic/msp_port.sv ***
// serial slave port: byte shifter, transfer buffers, sync outputs
// Notes on behaviour
// - act only while select is held low
// - reset low clears port and buffers
// - shift out on MISO, take MOSI
// - most significant bit first both ways
// - eight-bit units in both directions
// - 128-byte buffer queues several requests
// - pins synchronised into module clock domain
// - answer each request with process data
// - real-time and remote-call paths kept separate
// - sync outputs driven only with protocol active
`default_nettype none

module msp_port #(
  parameter int unsigned CLASS_DEPTH = msp_pkg::CLASS_BYTES,
  parameter int unsigned TX_DEPTH    = msp_pkg::TX_DEPTH
) (
  input  wire logic               clk_sys,         // system clock
  input  wire logic               rst_n,           // sync reset, low
  input  wire logic               spi_ss_n,        // target select pin
  input  wire logic               spi_sclk,        // serial clock pin
  input  wire logic               spi_mosi,        // data from master
  output logic                    spi_miso,        // data to master
  output logic                    spi_miso_oe,     // miso driven
  input  wire logic               spi_cpol,        // clock idle level
  input  wire logic               spi_cpha,        // sample on 2nd edge
  input  wire logic               tx_valid,        // answer byte offered
  input  wire logic [7:0]         tx_data,         // answer byte
  output logic                    tx_ready,        // answer byte taken
  output logic                    rt_valid,        // real-time byte
  output var msp_pkg::msp_rx_t    rt_req,          // real-time request
  input  wire logic               rt_ready,        // real-time taken
  output logic                    rc_valid,        // remote-call byte
  output var msp_pkg::msp_rx_t    rc_req,          // remote-call request
  input  wire logic               rc_ready,        // remote-call taken
  output logic                    rx_overrun_q,    // byte lost, pulse
  input  wire logic               dc_enable,       // dc protocol active
  input  wire logic               dc_sync_req_a,   // internal sync a
  input  wire logic               dc_sync_req_b,   // internal sync b
  output logic                    dc_sync_pulse_a, // sync output a
  output logic                    dc_sync_oe_a,    // sync a driven
  output logic                    dc_sync_pulse_b, // sync output b
  output logic                    dc_sync_oe_b     // sync b driven
);

  localparam int unsigned RXW = $bits(msp_pkg::msp_rx_t);

  logic [msp_pkg::PIN_W-1:0] pins_s;
  logic                      ssn_s, sclk_s, mosi_s;
  msp_pkg::msp_state_t       state_q, state_d;
  logic [2:0]                bit_cnt_q, bit_cnt_d;
  logic [7:0]                rx_sh_q, rx_sh_d;
  logic [7:0]                tx_sh_q, tx_sh_d;
  logic                      sclk_prev_q, sclk_prev_d;
  logic                      pend_q, pend_d;
  logic                      first_q, first_d;
  logic                      cls_q, cls_d;
  logic                      first_bit_q, first_bit_d;
  logic                      miso_oe_d, overrun_d;
  logic                      rise, fall, lead, trail;
  logic                      active, start, sample, shift;
  logic                      push, push_cls, load;
  logic [7:0]                rx_byte, tx_byte;
  msp_pkg::msp_rx_t          rx_word;
  logic                      rt_in_valid, rc_in_valid;
  logic                      rt_in_ready, rc_in_ready;
  logic                      tx_out_valid, tx_pop;
  logic [7:0]                tx_out_data;
  logic                      dc_a_d, dc_b_d, dc_oe_d;

  // pins cross into the module clock before any logic reads them
  msp_sync #(
    .W       (msp_pkg::PIN_W),
    .RST_VAL (msp_pkg::PIN_RST)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       ({spi_ss_n, spi_sclk, spi_mosi}),
    .sync_q  (pins_s)
  );

  assign ssn_s  = pins_s[msp_pkg::PIN_SS];
  assign sclk_s = pins_s[msp_pkg::PIN_SCLK];
  assign mosi_s = pins_s[msp_pkg::PIN_MOSI];

  // answer bytes queued by the process-data side
  msp_fifo #(
    .WIDTH     (msp_pkg::BYTE_BITS),
    .DEPTH     (TX_DEPTH)
  ) u_tx_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (tx_valid),
    .in_data   (tx_data),
    .in_ready  (tx_ready),
    .out_valid (tx_out_valid),
    .out_data  (tx_out_data),
    .out_ready (tx_pop)
  );

  // two halves of the transfer buffer so neither class blocks the other
  msp_fifo #(
    .WIDTH     (RXW),
    .DEPTH     (CLASS_DEPTH)
  ) u_rt_buf (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (rt_in_valid),
    .in_data   (rx_word),
    .in_ready  (rt_in_ready),
    .out_valid (rt_valid),
    .out_data  (rt_req),
    .out_ready (rt_ready)
  );

  msp_fifo #(
    .WIDTH     (RXW),
    .DEPTH     (CLASS_DEPTH)
  ) u_rc_buf (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (rc_in_valid),
    .in_data   (rx_word),
    .in_ready  (rc_in_ready),
    .out_valid (rc_valid),
    .out_data  (rc_req),
    .out_ready (rc_ready)
  );

  // edge finder and shift engine
  always_comb
  begin
    sclk_prev_d = sclk_s;
    rise        = sclk_s && !sclk_prev_q;
    fall        = !sclk_s && sclk_prev_q;
    lead        = spi_cpol ? fall : rise;
    trail       = spi_cpol ? rise : fall;
    active      = (state_q == msp_pkg::ST_ACTIVE) && !ssn_s;
    start       = (state_q == msp_pkg::ST_IDLE) && !ssn_s;
    sample      = active && (spi_cpha ? trail : lead);
    shift       = active && (spi_cpha ? lead : trail);
    tx_byte     = tx_out_valid ? tx_out_data : msp_pkg::IDLE_FILL;
    rx_byte     = {rx_sh_q[6:0], mosi_s};

    state_d     = state_q;
    bit_cnt_d   = bit_cnt_q;
    rx_sh_d     = rx_sh_q;
    tx_sh_d     = tx_sh_q;
    pend_d      = pend_q;
    first_d     = first_q;
    cls_d       = cls_q;
    first_bit_d = first_bit_q;
    miso_oe_d   = spi_miso_oe;
    push        = 1'b0;
    load        = 1'b0;
    push_cls    = first_q ? rx_byte[msp_pkg::RC_FLAG_BIT] : cls_q;

    if (ssn_s)
    begin
      state_d   = msp_pkg::ST_IDLE;
      miso_oe_d = 1'b0;
    end
    else if (start)
    begin
      state_d   = msp_pkg::ST_ACTIVE;
      bit_cnt_d = msp_pkg::BIT_FIRST;
      pend_d    = 1'b0;
      first_d   = 1'b1;
      miso_oe_d = 1'b1;
      load      = 1'b1;
    end
    else if (sample)
    begin
      rx_sh_d   = rx_byte;
      bit_cnt_d = bit_cnt_q + 1'b1;
      pend_d    = 1'b1;
      if (bit_cnt_q == msp_pkg::BIT_FIRST)
        first_bit_d = mosi_s;
      if (bit_cnt_q == msp_pkg::BIT_LAST)
      begin
        push    = 1'b1;
        cls_d   = push_cls;
        first_d = 1'b0;
      end
    end
    else if (shift && pend_q)
    begin
      pend_d = 1'b0;
      if (bit_cnt_q == msp_pkg::BIT_FIRST)
        load = 1'b1;
      else
        tx_sh_d = {tx_sh_q[6:0], 1'b0};
    end

    if (load)
      tx_sh_d = tx_byte;
    tx_pop      = load && tx_out_valid;
    rx_word     = '{first: first_q, data: rx_byte};
    rt_in_valid = push && !push_cls;
    rc_in_valid = push && push_cls;
    overrun_d   = (rt_in_valid && !rt_in_ready)
               || (rc_in_valid && !rc_in_ready);
  end

  assign spi_miso = tx_sh_q[7];

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_q      <= msp_pkg::ST_IDLE;
      bit_cnt_q    <= msp_pkg::BIT_FIRST;
      rx_sh_q      <= '0;
      tx_sh_q      <= '0;
      sclk_prev_q  <= 1'b0;
      pend_q       <= 1'b0;
      first_q      <= 1'b1;
      cls_q        <= 1'b0;
      first_bit_q  <= 1'b0;
      spi_miso_oe  <= 1'b0;
      rx_overrun_q <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      bit_cnt_q    <= bit_cnt_d;
      rx_sh_q      <= rx_sh_d;
      tx_sh_q      <= tx_sh_d;
      sclk_prev_q  <= sclk_prev_d;
      pend_q       <= pend_d;
      first_q      <= first_d;
      cls_q        <= cls_d;
      first_bit_q  <= first_bit_d;
      spi_miso_oe  <= miso_oe_d;
      rx_overrun_q <= overrun_d;
    end
  end

  // distributed-clock sync outputs, released when the protocol is off
  always_comb
  begin
    dc_oe_d = dc_enable;
    dc_a_d  = dc_enable && dc_sync_req_a;
    dc_b_d  = dc_enable && dc_sync_req_b;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      dc_sync_pulse_a <= 1'b0;
      dc_sync_pulse_b <= 1'b0;
      dc_sync_oe_a    <= 1'b0;
      dc_sync_oe_b    <= 1'b0;
    end
    else
    begin
      dc_sync_pulse_a <= dc_a_d;
      dc_sync_pulse_b <= dc_b_d;
      dc_sync_oe_a    <= dc_oe_d;
      dc_sync_oe_b    <= dc_oe_d;
    end
  end

  miso_off_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ssn_s |=> !spi_miso_oe)
    else $error("miso driven while deselected");

  miso_on_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    start |=> (spi_miso_oe && spi_miso == $past(tx_byte[7])))
    else $error("miso not driven with first bit at selection");

  idle_quiet_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (ssn_s || state_q == msp_pkg::ST_IDLE) |-> !(push || tx_pop && !start))
    else $error("activity while not selected");

  byte_len_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    push |-> (sample && bit_cnt_q == msp_pkg::BIT_LAST))
    else $error("byte pushed outside the eighth sample");

  msb_first_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    push |-> (rx_word.data[7] == first_bit_q && rx_word.data[0] == mosi_s))
    else $error("received byte not msb first");

  tx_load_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (load && tx_out_valid) |=> (tx_sh_q == $past(tx_out_data)))
    else $error("answer byte not loaded into shifter");

  class_split_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    push |-> (rt_in_valid != rc_in_valid)
             && (rc_in_valid == push_cls))
    else $error("byte routed to wrong class");

  reset_clear_a: assert property (
    @(posedge clk_sys)
    !rst_n |=> (!spi_miso_oe && !rt_valid && !rc_valid
                && state_q == msp_pkg::ST_IDLE))
    else $error("reset did not clear the port");

  dc_gate_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !dc_enable |=> (!dc_sync_oe_a && !dc_sync_oe_b
                    && !dc_sync_pulse_a && !dc_sync_pulse_b))
    else $error("sync output driven with protocol off");

endmodule

`default_nettype wire

// *** verif/msp_master_model.sv ***
// behavioural serial master driving the host port pins
`default_nettype none

module msp_master_model (
  input  wire logic cpol, // clock idle level
  input  wire logic cpha, // sample on trailing edge
  input  wire logic miso, // resolved data line
  output logic      ss_n, // select, active low
  output logic      sclk, // serial clock
  output logic      mosi  // data to port
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 32;

  initial
  begin
    ss_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // clock parks at its idle level before select falls
  task automatic sel();
    sclk = cpol;
    #40;
    ss_n = 1'b0;
    #HALF;
  endtask

  // released data line shows the inverse of its last bit
  task automatic desel();
    #HALF;
    ss_n = 1'b1;
    mosi = ~mosi;
    #40;
  endtask

  // clock edges while deselected
  task automatic stray();
    repeat (8)
    begin
      sclk = ~sclk;
      mosi = ~mosi;
      #HALF;
    end
  endtask

  task automatic xfer(input logic [7:0] tx, input int nbits,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--)
    begin
      if (!cpha)
      begin
        mosi = tx[i];
        #HALF;
        sclk = ~cpol;
        rx[i] = miso;
        #HALF;
        sclk = cpol;
      end
      else
      begin
        sclk = ~cpol;
        mosi = tx[i];
        #HALF;
        sclk = cpol;
        rx[i] = miso;
        #HALF;
      end
    end
  endtask
endmodule

`default_nettype wire

// *** verif/module_spi_host_port_tb.sv ***
// self-checking bench of the serial host port
`default_nettype none

module module_spi_host_port_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic             clk_sys = 1'b0;
  logic             rst_n, ss_n, sclk, mosi, miso, miso_oe;
  logic             cpol, cpha, tx_valid, tx_ready, rt_valid, rt_ready;
  logic             rc_valid, rc_ready, ovr, dc_en, req_a, req_b;
  logic             pa, oa, pb, ob, live, hold_rt;
  logic [7:0]       tx_data, exp_tx[$];
  logic [31:0]      seed;
  msp_pkg::msp_rx_t rt_req, rc_req, exp_rt[$], exp_rc[$];
  int               fail_count, compares, ovr_cnt, c;
  wire logic        miso_w;

  // undriven line shows a pattern that changes every half cycle
  assign miso_w = miso_oe ? miso : clk_sys;

  msp_port i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .spi_ss_n(ss_n),
    .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso),
    .spi_miso_oe(miso_oe), .spi_cpol(cpol), .spi_cpha(cpha),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .rt_valid(rt_valid), .rt_req(rt_req), .rt_ready(rt_ready),
    .rc_valid(rc_valid), .rc_req(rc_req), .rc_ready(rc_ready),
    .rx_overrun_q(ovr), .dc_enable(dc_en), .dc_sync_req_a(req_a),
    .dc_sync_req_b(req_b), .dc_sync_pulse_a(pa), .dc_sync_oe_a(oa),
    .dc_sync_pulse_b(pb), .dc_sync_oe_b(ob));

  msp_master_model i_mst (.cpol(cpol), .cpha(cpha), .miso(miso_w),
    .ss_n(ss_n), .sclk(sclk), .mosi(mosi));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // answer byte the port should send next
  function automatic logic [7:0] next_tx();
    return exp_tx.size() ? exp_tx.pop_front() : msp_pkg::IDLE_FILL;
  endfunction

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic rst_chk();
    chk("rst", {miso_oe, rt_valid, rc_valid, tx_ready, ovr}, 5'h02);
  endtask

  // offer answer bytes until n taken or the buffer refuses
  task automatic fill(input int n, output int k);
    int  idle;
    logic acc;
    k = 0;
    idle = 0;
    tx_data = 8'(rnd());
    tx_valid = 1'b1;
    while (k < n && idle < 8)
    begin
      @(posedge clk_sys);
      acc = tx_ready;
      idle = acc ? 0 : idle + 1;
      if (acc)
        exp_tx.push_back(tx_data);
      k += acc;
      @(negedge clk_sys);
      if (acc)
        tx_data = 8'(rnd());
    end
    tx_valid = 1'b0;
  endtask

  // header bit picks the class; bytes past room are expected lost
  task automatic frame(input logic [7:0] hdr, input int n, input int room);
    logic [7:0]       d, r, e;
    msp_pkg::msp_rx_t x;
    i_mst.sel();
    for (int k = 0; k < n; k++)
    begin
      d = (k == 0) ? hdr : 8'(rnd());
      e = next_tx();
      x.first = (k == 0);
      x.data = d;
      if (k < room && hdr[msp_pkg::RC_FLAG_BIT])
        exp_rc.push_back(x);
      else if (k < room)
        exp_rt.push_back(x);
      i_mst.xfer(d, 8, r);
      chk("miso", r, e);
    end
    // first-edge sampling preloads one more byte at the last trailing edge
    if (!cpha)
      void'(next_tx());
    i_mst.desel();
    repeat (10) @(negedge clk_sys);
  endtask

  initial
  begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    live <= rst_n;
    ovr_cnt += ovr;
    if (rt_valid && rt_ready)
    begin
      chk("rt_more", exp_rt.size() > 0, 1);
      if (exp_rt.size())
        chk("rt_req", rt_req, exp_rt.pop_front());
    end
    if (rc_valid && rc_ready)
    begin
      chk("rc_more", exp_rc.size() > 0, 1);
      if (exp_rc.size())
        chk("rc_req", rc_req, exp_rc.pop_front());
    end
  end

  // sync outputs follow enable and request one cycle late
  always @(negedge clk_sys)
  begin
    logic [31:0] r;
    chk("sync_a", pa, live & dc_en & req_a);
    chk("oe_a", oa, live & dc_en);
    chk("sync_b", pb, live & dc_en & req_b);
    chk("oe_b", ob, live & dc_en);
    r = rnd();
    {dc_en, req_a, req_b} = r[2:0];
    rt_ready = r[3] & ~hold_rt;
    rc_ready = r[4];
  end

  initial
  begin
    #300000;
    fail_count++;
    print_verdict();
  end

  initial
  begin
    seed = 32'h0000_0004;
    {rst_n, cpol, cpha, tx_valid, tx_data} = 12'h000;
    {dc_en, req_a, req_b, rt_ready, rc_ready, hold_rt} = 6'h00;
    {live, fail_count, compares, ovr_cnt} = '0;
    repeat (5) @(negedge clk_sys);
    rst_chk();
    rst_n = 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      {cpol, cpha} = 2'(m);
      fill(3, c);
      frame(8'(rnd()), 4, 4);
    end
    i_mst.stray();
    repeat (10) @(negedge clk_sys);
    chk("oe_idle", miso_oe, 0);
    i_mst.sel();
    i_mst.xfer(8'hA5, 4, c);
    chk("part", c, msp_pkg::IDLE_FILL);
    i_mst.desel();
    repeat (10) @(negedge clk_sys);
    frame(8'h3C, 2, 2);
    fill(40, c);
    chk("tx_room", c, msp_pkg::TX_DEPTH + 1);
    frame(8'h81, msp_pkg::TX_DEPTH + 2, 99);
    hold_rt = 1'b1;
    ovr_cnt = 0;
    frame(8'h11, msp_pkg::CLASS_BYTES + 6, msp_pkg::CLASS_BYTES + 1);
    chk("overrun", ovr_cnt, 5);
    frame(8'hC2, 5, 5);
    repeat (20) @(negedge clk_sys);
    chk("rc_flow", exp_rc.size(), 0);
    hold_rt = 1'b0;
    repeat (300) @(negedge clk_sys);
    fill(2, c);
    hold_rt = 1'b1;
    frame(8'h01, 3, 3);
    rst_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    rst_chk();
    rst_n = 1'b1;
    exp_rt.delete();
    exp_tx.delete();
    hold_rt = 1'b0;
    frame(8'h42, 2, 2);
    repeat (50) @(negedge clk_sys);
    chk("rt_rest", exp_rt.size(), 0);
    chk("rc_rest", exp_rc.size(), 0);
    print_verdict();
  end
endmodule

`default_nettype wire
